// File: bench/csc_config_bytes_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module csc_config_bytes_asserts import csc_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic frame_stop,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte,
  input wire logic [2:0] spread_code,
  input wire logic spread_active,
  input wire logic spread_down,
  input wire logic freq_from_soft,
  input wire logic [7:0] free_pci_ref_enables,
  input wire logic [1:0] current_mult_code,
  input wire logic [2:0] current_mult_factor,
  input wire logic shared_pin_rate_choice,
  input wire logic dual_rate_choice
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // command, one quiet cycle, then a lone data or read cycle
  sequence s_cmd(logic [7:0] c, logic g);
    cmd_valid && cmd_byte == c ##1 !cmd_valid && !frame_stop && !wr_valid && !rd_req
      ##1 g && !cmd_valid && !frame_stop;
  endsequence

  chk_rd_answer: assert property (rd_req && !cmd_valid && !frame_stop |=> rd_valid)
    else $error("read request got no answer");
  chk_rd_quiet: assert property (!rd_req |=> !rd_valid)
    else $error("read answer without request");
  chk_rd_hold: assert property (!rd_valid |-> $stable(rd_byte))
    else $error("read data moved between answers");
  chk_spread_decode: assert property (spread_active == spread_code[2] && spread_down == (spread_code == SPREAD_DOWN_050))
    else $error("spread decode wrong");
  chk_mult_factor: assert property (current_mult_factor == 3'h4 + {1'b0, current_mult_code})
    else $error("multiplier factor wrong");
  chk_rsv_zero: assert property (free_pci_ref_enables[4] == 1'b0 && free_pci_ref_enables[2] == 1'b0)
    else $error("reserved enable bit set");
  chk_byte5_write: assert property (s_cmd(8'h85, wr_valid) |-> ##2 {freq_from_soft, shared_pin_rate_choice, dual_rate_choice} == $past(wr_byte[2:0], 2))
    else $error("select bits do not follow write");
  chk_ident_read: assert property (s_cmd(8'h86, rd_req) |=> rd_valid && rd_byte == {REVISION_CODE, MAKER_CODE})
    else $error("identification read wrong");
  chk_block_count: assert property (s_cmd(CMD_BLOCK, rd_req) |=> rd_byte == BLOCK_LEN)
    else $error("block count wrong");

  // main scenarios reached
  cover property (s_cmd(8'h85, wr_valid));
  cover property (s_cmd(CMD_BLOCK, rd_req));
  cover property (spread_down);
endmodule
`default_nettype wire

// File: bench/csc_config_bytes_test.sv
`timescale 1ns/100ps
`default_nettype none
module csc_config_bytes_test import csc_pkg::*;;
  logic clk, rstn, frame_stop, cmd_valid, wr_valid, rd_req, rd_valid;
  logic [7:0] cmd_byte, wr_byte, rd_byte, cpu_misc_enables, free_pci_ref_enables;
  logic [4:0] strap_freq_pins, freq_code;
  logic [1:0] current_mult_pins, current_mult_code;
  logic [2:0] spread_code, current_mult_factor;
  logic [6:0] pci_enables;
  logic spread_active, spread_down, freq_from_soft, shared_pin_rate_choice, dual_rate_choice;
  int n_errors = 0;
  int check_count = 0;
  logic [7:0] rst_tab [0:6] = '{8'h00, 8'hFF, 8'h7F, 8'hEB, 8'h00, 8'h58, {REVISION_CODE, MAKER_CODE}};
  logic [7:0] blk_tab [0:6] = '{8'h83, 8'hC3, 8'h00, 8'hEB, 8'h60, 8'h5A, {REVISION_CODE, MAKER_CODE}};

  csc_config_bytes i_dut (.clk, .rstn, .frame_stop, .cmd_valid, .cmd_byte, .wr_valid, .wr_byte, .rd_req,
    .rd_valid, .rd_byte, .strap_freq_pins, .current_mult_pins, .spread_code, .spread_active, .spread_down,
    .freq_code, .freq_from_soft, .cpu_misc_enables, .pci_enables, .free_pci_ref_enables, .current_mult_code,
    .current_mult_factor, .shared_pin_rate_choice, .dual_rate_choice);
  csc_host_model i_host (.clk, .frame_stop, .cmd_valid, .cmd_byte, .wr_valid, .wr_byte, .rd_req, .rd_valid,
    .rd_byte);

  // ==========================================================
  // comparison, access helpers and verdict
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic take_rd(input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    i_host.fetch_rd(d, ok);
    if (!ok) begin
      n_errors++;
      $display("ERROR %0t: read not answered", $time);
    end
    check(d, exp);
  endtask
  task automatic wr_at(input logic [6:0] idx, input logic [7:0] d);
    i_host.send_cmd({1'b1, idx});
    i_host.send_wr(d);
    i_host.end_frame();
  endtask
  task automatic expect_rd(input logic [6:0] idx, input logic [7:0] exp);
    i_host.send_cmd({1'b1, idx});
    take_rd(exp);
    i_host.end_frame();
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    check(cpu_misc_enables, 8'hFF);
    check({1'b0, pci_enables}, 8'h7F);
    check(free_pci_ref_enables, 8'hEB);
    check({3'h0, freq_code}, 8'h0B);
    check({6'h00, current_mult_code}, 8'h02);
    for (int i = 0; i < 7; i++) expect_rd(i[6:0], rst_tab[i]);
    $display("t_reset done");
  endtask
  task automatic t_spread();
    for (int c = 0; c < 8; c++) begin
      wr_at(7'h00, {c[2:0], 5'h15});
      check({5'h00, spread_code}, {5'h00, c[2:0]});
      check({6'h00, spread_active, spread_down}, {6'h00, c[2], c[2:0] == 3'h5});
    end
    $display("t_spread done");
  endtask
  task automatic t_freq();
    wr_at(7'h05, 8'hFF);
    check({3'h0, freq_code}, 8'h15);
    check({5'h00, freq_from_soft, shared_pin_rate_choice, dual_rate_choice}, 8'h07);
    expect_rd(7'h05, 8'h5F);
    wr_at(7'h05, 8'h02);
    check({3'h0, freq_code}, 8'h0B);
    check({5'h00, freq_from_soft, shared_pin_rate_choice, dual_rate_choice}, 8'h02);
    $display("t_freq done");
  endtask
  task automatic t_mult();
    for (int k = 0; k < 4; k++) begin
      wr_at(7'h04, {1'b1, k[1:0], 5'h1F});
      check({6'h00, current_mult_code}, {6'h00, k[1:0]});
      check({5'h00, current_mult_factor}, 8'h04 + 8'(k));
      expect_rd(7'h04, {1'b1, k[1:0], 5'h00});
    end
    wr_at(7'h04, 8'h60);
    check({6'h00, current_mult_code}, 8'h02);
    current_mult_pins = 2'b01;
    repeat (6) @(negedge clk);
    check({6'h00, current_mult_code}, 8'h01);
    check({5'h00, current_mult_factor}, 8'h05);
    $display("t_mult done");
  endtask
  task automatic t_enables();
    wr_at(7'h03, 8'h00);
    check(free_pci_ref_enables, 8'h00);
    wr_at(7'h03, 8'hFF);
    expect_rd(7'h03, 8'hEB);
    wr_at(7'h02, 8'h80);
    check({1'b0, pci_enables}, 8'h00);
    expect_rd(7'h02, 8'h00);
    wr_at(7'h06, 8'h00);
    expect_rd(7'h06, {REVISION_CODE, MAKER_CODE});
    $display("t_enables done");
  endtask
  task automatic t_block();
    i_host.send_cmd(CMD_BLOCK);
    i_host.send_wr(8'h02);
    i_host.send_wr(8'h83);
    i_host.send_wr(8'hC3);
    i_host.send_wr(8'h11);
    i_host.end_frame();
    check(cpu_misc_enables, 8'hC3);
    i_host.send_cmd(CMD_BLOCK);
    take_rd(8'h07);
    for (int i = 0; i < 7; i++) take_rd(blk_tab[i]);
    i_host.end_frame();
    $display("t_block done");
  endtask
  task automatic t_refused();
    i_host.send_cmd(8'h01);
    i_host.send_wr(8'hFF);
    take_rd(8'h00);
    i_host.end_frame();
    expect_rd(7'h00, 8'h83);
    expect_rd(7'h07, 8'h00);
    $display("t_refused done");
  endtask
  task automatic t_rereset();
    @(negedge clk);
    rstn = 1'b0;
    strap_freq_pins = 5'h14;
    current_mult_pins = 2'b11;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (10) @(negedge clk);
    check({3'h0, freq_code}, 8'h14);
    check({5'h00, current_mult_factor}, 8'h07);
    check({5'h00, spread_code}, 8'h00);
    check({5'h00, freq_from_soft, shared_pin_rate_choice, dual_rate_choice}, 8'h00);
    expect_rd(7'h05, 8'hA0);
    expect_rd(7'h00, 8'h00);
    $display("t_rereset done");
  endtask

  // ==========================================================
  // clock and main sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    strap_freq_pins = 5'h0B;
    current_mult_pins = 2'b10;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (10) @(negedge clk);
    t_reset();
    t_spread();
    t_freq();
    t_mult();
    t_enables();
    t_block();
    t_refused();
    t_rereset();
    stop_test();
  end
endmodule

bind csc_config_bytes csc_config_bytes_asserts i_chk (.*);
`default_nettype wire

// File: bench/csc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module csc_host_model (
  input wire logic clk,
  output logic frame_stop,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  output logic rd_req,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte
);
  // idle lines, data buses hold no meaningful value
  initial begin
    frame_stop = 1'b0;
    cmd_valid = 1'b0;
    cmd_byte = 8'hA5;
    wr_valid = 1'b0;
    wr_byte = 8'h5A;
    rd_req = 1'b0;
  end
  // top bit set picks one byte by index, all zero picks a block
  task automatic send_cmd(input logic [7:0] c);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_byte = c;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_byte = ~c;
  endtask
  // one written byte, bus inverted once released
  task automatic send_wr(input logic [7:0] d);
    @(negedge clk);
    wr_valid = 1'b1;
    wr_byte = d;
    @(negedge clk);
    wr_valid = 1'b0;
    wr_byte = ~d;
  endtask
  // answer is due one cycle after the request edge
  task automatic fetch_rd(output logic [7:0] d, output logic ok);
    @(negedge clk);
    rd_req = 1'b1;
    @(negedge clk);
    rd_req = 1'b0;
    ok = (rd_valid === 1'b1);
    d = rd_byte;
  endtask
  // stop condition closes the access
  task automatic end_frame();
    @(negedge clk);
    frame_stop = 1'b1;
    @(negedge clk);
    frame_stop = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: logic/csc_config_bytes.sv
`timescale 1ns/100ps
`default_nettype none
module csc_config_bytes import csc_pkg::*; (
  clk,
  rstn,
  frame_stop,
  cmd_valid,
  cmd_byte,
  wr_valid,
  wr_byte,
  rd_req,
  rd_valid,
  rd_byte,
  strap_freq_pins,
  current_mult_pins,
  spread_code,
  spread_active,
  spread_down,
  freq_code,
  freq_from_soft,
  cpu_misc_enables,
  pci_enables,
  free_pci_ref_enables,
  current_mult_code,
  current_mult_factor,
  shared_pin_rate_choice,
  dual_rate_choice
);
  input wire logic clk;
  input wire logic rstn;
  input wire logic frame_stop;
  input wire logic cmd_valid;
  input wire logic [7:0] cmd_byte;
  input wire logic wr_valid;
  input wire logic [7:0] wr_byte;
  input wire logic rd_req;
  output logic rd_valid;
  output logic [7:0] rd_byte;
  input wire logic [4:0] strap_freq_pins;
  input wire logic [1:0] current_mult_pins;
  output logic [2:0] spread_code;
  output logic spread_active;
  output logic spread_down;
  output logic [4:0] freq_code;
  output logic freq_from_soft;
  output logic [7:0] cpu_misc_enables;
  output logic [6:0] pci_enables;
  output logic [7:0] free_pci_ref_enables;
  output logic [1:0] current_mult_code;
  output logic [2:0] current_mult_factor;
  output logic shared_pin_rate_choice;
  output logic dual_rate_choice;

  // ==========================================================
  // storage
  logic [7:0] spread_and_freq_select_q;
  logic [7:0] cpu_and_misc_enables_q;
  logic [7:0] pci_output_enables_q;
  logic [7:0] free_pci_ref_enables_q;
  logic [7:0] current_multiplier_ctrl_q;
  logic [2:0] strap_and_output_select_q;
  logic [4:0] strap_freq_latch_q;
  logic strap_done_q;
  logic [2:0] strap_cnt_q;
  logic [4:0] strap_sync;
  logic [1:0] mult_sync;
  csc_state_type state_q;
  logic [6:0] idx_q;
  logic [7:0] remain_q;
  logic wr_hit;
  logic [6:0] wr_idx;

  // writable bits of each byte, zero for read-only and unmapped
  function automatic logic [7:0] wr_mask(input logic [6:0] idx);
    unique case (idx)
      IDX_SPREAD_FREQ: wr_mask = MASK_SPREAD_FREQ;
      IDX_CPU_MISC_EN: wr_mask = MASK_CPU_MISC_EN;
      IDX_PCI_EN: wr_mask = MASK_PCI_EN;
      IDX_FREE_PCI_REF_EN: wr_mask = MASK_FREE_PCI_REF_EN;
      IDX_CURRENT_MULT: wr_mask = MASK_CURRENT_MULT;
      IDX_STRAP_OUT_SEL: wr_mask = MASK_STRAP_OUT_SEL;
      default: wr_mask = 8'h00;
    endcase
  endfunction

  // read view of each byte, reserved bits zero
  function automatic logic [7:0] rd_view(input logic [6:0] idx);
    unique case (idx)
      IDX_SPREAD_FREQ: rd_view = spread_and_freq_select_q;
      IDX_CPU_MISC_EN: rd_view = cpu_and_misc_enables_q;
      IDX_PCI_EN: rd_view = pci_output_enables_q & MASK_PCI_EN;
      IDX_FREE_PCI_REF_EN: rd_view = free_pci_ref_enables_q & MASK_FREE_PCI_REF_EN;
      IDX_CURRENT_MULT: rd_view = current_multiplier_ctrl_q & MASK_CURRENT_MULT;
      IDX_STRAP_OUT_SEL: rd_view = {strap_freq_latch_q, strap_and_output_select_q};
      IDX_IDENT: rd_view = {REVISION_CODE, MAKER_CODE};
      default: rd_view = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // pin synchronisers for straps and multiplier pins
  csc_pin_sync #(.WIDTH(5), .INIT(5'h00)) u_strap_sync (
    .clk(clk),
    .rstn(rstn),
    .pin_in(strap_freq_pins),
    .pin_out(strap_sync)
  );

  csc_pin_sync #(.WIDTH(2), .INIT(2'h0)) u_mult_sync (
    .clk(clk),
    .rstn(rstn),
    .pin_in(current_mult_pins),
    .pin_out(mult_sync)
  );

  // strap capture once, after sampling settles following reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_cnt_q <= 3'h0;
      strap_done_q <= 1'b0;
      strap_freq_latch_q <= 5'h00;
    end else if (!strap_done_q) begin
      if (strap_cnt_q == STRAP_WAIT) begin
        strap_freq_latch_q <= strap_sync;
        strap_done_q <= 1'b1;
      end else begin
        strap_cnt_q <= strap_cnt_q + 3'h1;
      end
    end
  end

  // ==========================================================
  // command decode and block sequencing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= CSC_IDLE;
      idx_q <= 7'h00;
      remain_q <= 8'h00;
    end else if (frame_stop) begin
      state_q <= CSC_IDLE;
    end else if (cmd_valid) begin
      if (cmd_byte[CMD_BYTE_BIT]) begin
        state_q <= CSC_SINGLE;
        idx_q <= cmd_byte[6:0];
      end else if (cmd_byte == CMD_BLOCK) begin
        state_q <= CSC_BLK_COUNT;
        idx_q <= 7'h00;
      end else begin
        state_q <= CSC_IDLE;
      end
    end else begin
      unique case (state_q)
        CSC_IDLE: begin
          state_q <= CSC_IDLE;
        end
        CSC_SINGLE: begin
          if (wr_valid) begin
            state_q <= CSC_IDLE;
          end
        end
        CSC_BLK_COUNT: begin
          if (wr_valid) begin
            remain_q <= wr_byte;
            state_q <= CSC_BLK_DATA;
          end else if (rd_req) begin
            remain_q <= BLOCK_LEN;
            state_q <= CSC_BLK_DATA;
          end
        end
        CSC_BLK_DATA: begin
          if ((wr_valid || rd_req) && remain_q != 8'h00) begin
            idx_q <= idx_q + 7'h01;
            remain_q <= remain_q - 8'h01;
          end
        end
      endcase
    end
  end

  // a data byte lands when a single access or a counted block slot is open
  assign wr_hit = wr_valid && !cmd_valid && !frame_stop &&
                  (state_q == CSC_SINGLE || (state_q == CSC_BLK_DATA && remain_q != 8'h00));
  assign wr_idx = idx_q;

  // ==========================================================
  // register writes, masked so reserved and read-only bits never change
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      spread_and_freq_select_q <= RST_SPREAD_FREQ;
      cpu_and_misc_enables_q <= RST_CPU_MISC_EN;
      pci_output_enables_q <= RST_PCI_EN;
      free_pci_ref_enables_q <= RST_FREE_PCI_REF_EN;
      current_multiplier_ctrl_q <= RST_CURRENT_MULT;
      strap_and_output_select_q <= RST_STRAP_OUT_SEL[2:0];
    end else if (wr_hit) begin
      unique case (wr_idx)
        IDX_SPREAD_FREQ: begin
          spread_and_freq_select_q <= wr_byte & wr_mask(wr_idx);
        end
        IDX_CPU_MISC_EN: begin
          cpu_and_misc_enables_q <= wr_byte & wr_mask(wr_idx);
        end
        IDX_PCI_EN: begin
          pci_output_enables_q <= wr_byte & wr_mask(wr_idx);
        end
        IDX_FREE_PCI_REF_EN: begin
          free_pci_ref_enables_q <= wr_byte & wr_mask(wr_idx);
        end
        IDX_CURRENT_MULT: begin
          current_multiplier_ctrl_q <= wr_byte & wr_mask(wr_idx);
        end
        IDX_STRAP_OUT_SEL: begin
          strap_and_output_select_q <= wr_byte[2:0];
        end
        default: begin
          spread_and_freq_select_q <= spread_and_freq_select_q;
        end
      endcase
    end
  end

  // ==========================================================
  // read answers one cycle after the request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid <= 1'b0;
      rd_byte <= 8'h00;
    end else begin
      rd_valid <= 1'b0;
      if (rd_req && !cmd_valid && !frame_stop) begin
        rd_valid <= 1'b1;
        unique case (state_q)
          CSC_SINGLE: begin
            rd_byte <= rd_view(idx_q);
          end
          CSC_BLK_COUNT: begin
            rd_byte <= BLOCK_LEN;
          end
          CSC_BLK_DATA: begin
            rd_byte <= (remain_q != 8'h00) ? rd_view(idx_q) : 8'h00;
          end
          CSC_IDLE: begin
            rd_byte <= 8'h00;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // spread decode, reserved codes leave spreading off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      spread_code <= SPREAD_OFF;
      spread_active <= 1'b0;
      spread_down <= 1'b0;
    end else begin
      spread_code <= spread_and_freq_select_q[SPREAD_MSB:SPREAD_LSB];
      unique case (spread_and_freq_select_q[SPREAD_MSB:SPREAD_LSB])
        SPREAD_CENTER_025, SPREAD_CENTER_050, SPREAD_CENTER_038: begin
          spread_active <= 1'b1;
          spread_down <= 1'b0;
        end
        SPREAD_DOWN_050: begin
          spread_active <= 1'b1;
          spread_down <= 1'b1;
        end
        default: begin
          spread_active <= 1'b0;
          spread_down <= 1'b0;
        end
      endcase
    end
  end

  // frequency source choice
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      freq_code <= 5'h00;
      freq_from_soft <= 1'b0;
    end else begin
      freq_from_soft <= strap_and_output_select_q[FREQ_SRC_BIT];
      if (strap_and_output_select_q[FREQ_SRC_BIT]) begin
        freq_code <= spread_and_freq_select_q[SOFT_FREQ_MSB:0];
      end else begin
        freq_code <= strap_freq_latch_q;
      end
    end
  end

  // output enables, reserved positions forced off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpu_misc_enables <= RST_CPU_MISC_EN;
      pci_enables <= RST_PCI_EN[6:0];
      free_pci_ref_enables <= RST_FREE_PCI_REF_EN;
    end else begin
      cpu_misc_enables <= cpu_and_misc_enables_q;
      pci_enables <= pci_output_enables_q[6:0];
      free_pci_ref_enables <= free_pci_ref_enables_q & MASK_FREE_PCI_REF_EN;
    end
  end

  // current multiplier source and factor
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      current_mult_code <= 2'h0;
      current_mult_factor <= CUR_MULT_BASE;
    end else begin
      if (current_multiplier_ctrl_q[CUR_MULT_SRC_BIT]) begin
        current_mult_code <= current_multiplier_ctrl_q[CUR_MULT_MSB:CUR_MULT_LSB];
        current_mult_factor <= CUR_MULT_BASE + {1'b0, current_multiplier_ctrl_q[CUR_MULT_MSB:CUR_MULT_LSB]};
      end else begin
        current_mult_code <= mult_sync;
        current_mult_factor <= CUR_MULT_BASE + {1'b0, mult_sync};
      end
    end
  end

  // shared pin and dual-rate selects
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shared_pin_rate_choice <= 1'b0;
      dual_rate_choice <= 1'b0;
    end else begin
      shared_pin_rate_choice <= strap_and_output_select_q[SHARED_PIN_BIT];
      dual_rate_choice <= strap_and_output_select_q[DUAL_RATE_BIT];
    end
  end

endmodule
`default_nettype wire

// File: logic/csc_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module csc_pin_sync import csc_pkg::*; #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  clk,
  rstn,
  pin_in,
  pin_out
);
  input wire logic clk;
  input wire logic rstn;
  input wire logic [WIDTH-1:0] pin_in;
  output logic [WIDTH-1:0] pin_out;

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // ==========================================================
  // three-stage sampling, a change counts when stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          s1_q[i] <= INIT[i];
          s2_q[i] <= INIT[i];
          s3_q[i] <= INIT[i];
          pin_out[i] <= INIT[i];
        end else begin
          s1_q[i] <= pin_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            pin_out[i] <= s3_q[i]; // agreed level
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// File: logic/csc_pkg.sv
package csc_pkg;

  // ==========================================================
  // byte indices
  localparam logic [6:0] IDX_SPREAD_FREQ = 7'h00;
  localparam logic [6:0] IDX_CPU_MISC_EN = 7'h01;
  localparam logic [6:0] IDX_PCI_EN = 7'h02;
  localparam logic [6:0] IDX_FREE_PCI_REF_EN = 7'h03;
  localparam logic [6:0] IDX_CURRENT_MULT = 7'h04;
  localparam logic [6:0] IDX_STRAP_OUT_SEL = 7'h05;
  localparam logic [6:0] IDX_IDENT = 7'h06;

  // block reads cover bytes 0 to 6, block writes cover as many bytes as their count byte gives
  localparam logic [7:0] BLOCK_LEN = 8'h07;

  // ==========================================================
  // command codes
  localparam int CMD_BYTE_BIT = 7;
  localparam logic [7:0] CMD_BLOCK = 8'h00;

  // ==========================================================
  // writable masks and reset values
  localparam logic [7:0] MASK_SPREAD_FREQ = 8'hFF;
  localparam logic [7:0] MASK_CPU_MISC_EN = 8'hFF;
  localparam logic [7:0] MASK_PCI_EN = 8'h7F;
  localparam logic [7:0] MASK_FREE_PCI_REF_EN = 8'hEB;
  localparam logic [7:0] MASK_CURRENT_MULT = 8'hE0;
  localparam logic [7:0] MASK_STRAP_OUT_SEL = 8'h07;
  localparam logic [7:0] RST_SPREAD_FREQ = 8'h00;
  localparam logic [7:0] RST_CPU_MISC_EN = 8'hFF;
  localparam logic [7:0] RST_PCI_EN = 8'h7F;
  localparam logic [7:0] RST_FREE_PCI_REF_EN = 8'hEB;
  localparam logic [7:0] RST_CURRENT_MULT = 8'h00;
  localparam logic [7:0] RST_STRAP_OUT_SEL = 8'h00;

  // ==========================================================
  // field positions
  localparam int SPREAD_MSB = 7;
  localparam int SPREAD_LSB = 5;
  localparam int SOFT_FREQ_MSB = 4;
  localparam int CUR_MULT_SRC_BIT = 7;
  localparam int CUR_MULT_MSB = 6;
  localparam int CUR_MULT_LSB = 5;
  localparam int STRAP_MSB = 7;
  localparam int STRAP_LSB = 3;
  localparam int FREQ_SRC_BIT = 2;
  localparam int SHARED_PIN_BIT = 1;
  localparam int DUAL_RATE_BIT = 0;

  // ==========================================================
  // spread codes
  localparam logic [2:0] SPREAD_OFF = 3'h0;
  localparam logic [2:0] SPREAD_CENTER_025 = 3'h4;
  localparam logic [2:0] SPREAD_DOWN_050 = 3'h5;
  localparam logic [2:0] SPREAD_CENTER_050 = 3'h6;
  localparam logic [2:0] SPREAD_CENTER_038 = 3'h7;

  // current multiplier base: code 00 means four times
  localparam logic [2:0] CUR_MULT_BASE = 3'h4;

  // identification, values arbitrary
  localparam logic [3:0] REVISION_CODE = 4'h2;
  localparam logic [3:0] MAKER_CODE = 4'h5;

  // strap capture waits this many cycles after reset release
  localparam logic [2:0] STRAP_WAIT = 3'h4;

  // transaction states
  typedef enum logic [1:0] {
    CSC_IDLE = 2'b00,
    CSC_SINGLE = 2'b01,
    CSC_BLK_COUNT = 2'b10,
    CSC_BLK_DATA = 2'b11
  } csc_state_type;

endpackage
